// file: include/ccxr_pkg.sv
// shared constants, field positions and carrier types of the cpu config,
// id and block translation register bank.
// assumes a 32-bit implementation; bit numbers are little-endian (bit 0 = lsb).

package ccxr_pkg;

  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int XLEN       = 32;
  localparam int IDX_W      = 15;
  localparam int SIZE_W     = 11;
  localparam int HALF_W     = 16;

  // ----------------------------------------------------------------------
  // machine state word field positions
  // ----------------------------------------------------------------------
  localparam int MSW_DOZE   = 18;
  localparam int MSW_TBO    = 16;
  localparam int MSW_AIRQ   = 15;
  localparam int MSW_USER   = 14;
  localparam int MSW_FPA    = 13;
  localparam int MSW_HWERR  = 12;
  localparam int MSW_FPLO   = 11;
  localparam int MSW_STEP   = 10;
  localparam int MSW_JUMP   = 9;
  localparam int MSW_FPHI   = 8;
  localparam int MSW_VHB    = 6;
  localparam int MSW_FXL    = 5;
  localparam int MSW_LXL    = 4;
  localparam int MSW_RST_F  = 1;
  localparam int MSW_SWAP   = 0;

  // values after reset; bits without a defined power-up value come up zero here
  localparam logic [31:0] MSW_RESET_BASE = 32'h0000_0000;
  localparam logic        VHB_RESET      = 1'h1;
  localparam logic [31:0] BXU_RESET      = 32'h0000_0000;
  localparam logic [31:0] BXL_RESET      = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // upper block register fields
  // ----------------------------------------------------------------------
  localparam int BXU_IDX_LSB  = 17;
  localparam int BXU_SIZE_LSB = 2;
  localparam int BXU_PRIV_V   = 1;
  localparam int BXU_USER_V   = 0;
  localparam logic [31:0] BXU_WMASK = 32'hfffe_1fff;

  // ----------------------------------------------------------------------
  // lower block register fields
  // ----------------------------------------------------------------------
  localparam int BXL_PHYS_LSB = 17;
  localparam int BXL_ATTR_LSB = 3;
  localparam int BXL_GUARD_LSB = 0;
  localparam logic [31:0] BXL_WMASK = 32'hfffe_007b;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CCXR_SEL_MSW,
    CCXR_SEL_MODEL,
    CCXR_SEL_BXU,
    CCXR_SEL_BXL
  } ccxr_sel_t;

  // codes are the {lo, hi} trap mode pair
  typedef enum logic [1:0] {
    CCXR_FP_OFF       = 2'h0,
    CCXR_FP_IMP_NOREC = 2'h1,
    CCXR_FP_IMP_REC   = 2'h2,
    CCXR_FP_PRECISE   = 2'h3
  } ccxr_fp_mode_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    ccxr_sel_t   sel;
    logic [31:0] wdata;
  } ccxr_spr_req_t;

  typedef struct packed {
    logic              hit;
    logic [IDX_W-1:0]  phys_hi;
    logic [3:0]        cache_attr;
    logic [1:0]        access_guard;
  } ccxr_xlate_t;

endpackage

// file: design/ccxr_block_match.sv
// effective-to-physical block match for one upper/lower register pair.
// purely combinational; the caller registers the result.

module ccxr_block_match (
  input  wire logic [31:0]         bxu_in,
  input  wire logic [31:0]         bxl_in,
  input  wire logic                user_level_in,
  input  wire logic                ea_valid_in,
  input  wire logic [31:0]         ea_in,
  output ccxr_pkg::ccxr_xlate_t    match_out
);

  logic [ccxr_pkg::IDX_W-1:0] ea_idx;
  logic [ccxr_pkg::IDX_W-1:0] blk_idx;
  logic [ccxr_pkg::IDX_W-1:0] size_mask;
  logic [ccxr_pkg::IDX_W-1:0] phys;
  logic                       state_ok;

  always_comb begin
    ea_idx    = ea_in[31:ccxr_pkg::BXU_IDX_LSB];
    blk_idx   = bxu_in[31:ccxr_pkg::BXU_IDX_LSB];
    phys      = bxl_in[31:ccxr_pkg::BXL_PHYS_LSB];
    // mask bits cover the low-order index bits that fall inside the block
    size_mask = {4'h0, bxu_in[ccxr_pkg::BXU_SIZE_LSB +: ccxr_pkg::SIZE_W]};
    state_ok  = user_level_in ? bxu_in[ccxr_pkg::BXU_USER_V]
                              : bxu_in[ccxr_pkg::BXU_PRIV_V];
    match_out.hit          = ea_valid_in & state_ok &
                             ((ea_idx & ~size_mask) == (blk_idx & ~size_mask));
    match_out.phys_hi      = (phys & ~size_mask) | (ea_idx & size_mask);
    match_out.cache_attr   = bxl_in[ccxr_pkg::BXL_ATTR_LSB +: 4];
    match_out.access_guard = bxl_in[ccxr_pkg::BXL_GUARD_LSB +: 2];
  end

endmodule

// file: design/ccxr_regs.sv
// cpu configuration, model id and block translation register bank.
// assumes requests come from the special-register move path on sys_clk_in
// and an effective address from the fetch/load unit on the same clock.
//
// What this block does
// - decode trap mode pair: 00 off, 01 imprecise nonrec, 10 imprecise rec, 11 precise
// - optional: either trap mode bit set selects precise mode
// - reset clears the listed state bits; 64-bit form sets wide mode
// - high vector base bit resets to one, may be built as zero
// - state bits without a power-up value are unspecified for software
// - model id register is 32-bit, read-only, supervisor read only
// - model id: version in bits 0-15, revision in bits 16-31
// - revision value is implementation-specific and changes each device revision
// - reading model id copies the whole word to the general register
// - size mask field sits in upper bits 19-29, encodes block size
// - supervisor valid bit gates a match in supervisor state
// - user valid bit gates a match in user state
// - on hit physical high bits merge phys number and address under mask
// - lower bits 25-28 give write-through, inhibit, coherence, guarded attributes
// - lower bits 30-31 hold the block protection bits
// - size mask is a right-aligned run of ones, each one doubles size
// - user-level flag zero allows supervisor work; one allows user only

module ccxr_regs #(
  parameter logic        IMPL_64      = 1'h0,
  parameter logic        FP_OR_MODE   = 1'h0,
  parameter logic        VHB_RESET    = ccxr_pkg::VHB_RESET,
  // arbitrary identification values
  parameter logic [15:0] MODEL_VER    = 16'h0a5c,
  parameter logic [15:0] MODEL_REV    = 16'h0001
) (
  input  wire logic                    sys_clk_in,
  input  wire logic                    srst_in,
  input  wire logic                    ce_in,
  input  wire ccxr_pkg::ccxr_spr_req_t spr_req_in,
  input  wire logic                    ea_valid_in,
  input  wire logic [31:0]             ea_in,
  output      logic                    spr_ack_out,
  output      logic                    spr_fault_out,
  output      logic [31:0]             spr_rdata_out,
  output      logic [31:0]             msw_out,
  output      logic                    wide_mode_64_out,
  output      ccxr_pkg::ccxr_fp_mode_t fp_mode_out,
  output      logic                    fp_precise_out,
  output      ccxr_pkg::ccxr_xlate_t   xlate_out
);

  // ----------------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------------
  localparam logic [31:0] MODEL_ID  = {MODEL_VER, MODEL_REV};
  localparam logic [31:0] MSW_RESET = ccxr_pkg::MSW_RESET_BASE |
                                      (32'(VHB_RESET) << ccxr_pkg::MSW_VHB);

  function automatic ccxr_pkg::ccxr_fp_mode_t fp_decode(input logic [31:0] w);
    fp_decode = ccxr_pkg::ccxr_fp_mode_t'({w[ccxr_pkg::MSW_FPLO], w[ccxr_pkg::MSW_FPHI]});
  endfunction

  function automatic logic fp_precise(input logic [31:0] w);
    if (FP_OR_MODE) begin
      fp_precise = w[ccxr_pkg::MSW_FPLO] | w[ccxr_pkg::MSW_FPHI];
    end else begin
      fp_precise = w[ccxr_pkg::MSW_FPLO] & w[ccxr_pkg::MSW_FPHI];
    end
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [31:0]             msw_q,   msw_d;
  logic [31:0]             bxu_q,   bxu_d;
  logic [31:0]             bxl_q,   bxl_d;
  logic [31:0]             rdata_q, rdata_d;
  logic                    ack_q,   ack_d;
  logic                    fault_q, fault_d;
  logic                    wide_q;
  ccxr_pkg::ccxr_fp_mode_t fpm_q,   fpm_d;
  logic                    fpp_q,   fpp_d;
  ccxr_pkg::ccxr_xlate_t   xl_q;
  ccxr_pkg::ccxr_xlate_t   xl_d;
  logic                    supervisor;

  // ----------------------------------------------------------------------
  // special register moves
  // ----------------------------------------------------------------------
  always_comb begin
    msw_d      = msw_q;
    bxu_d      = bxu_q;
    bxl_d      = bxl_q;
    rdata_d    = rdata_q;
    ack_d      = 1'h0;
    fault_d    = 1'h0;
    supervisor = ~msw_q[ccxr_pkg::MSW_USER];
    if (spr_req_in.valid) begin
      if (!supervisor) begin
        fault_d = 1'h1;
      end else if (spr_req_in.write) begin
        unique case (spr_req_in.sel)
          ccxr_pkg::CCXR_SEL_MSW: begin
            msw_d = spr_req_in.wdata;
            ack_d = 1'h1;
          end
          ccxr_pkg::CCXR_SEL_MODEL: begin
            fault_d = 1'h1;
          end
          ccxr_pkg::CCXR_SEL_BXU: begin
            bxu_d = spr_req_in.wdata & ccxr_pkg::BXU_WMASK;
            ack_d = 1'h1;
          end
          ccxr_pkg::CCXR_SEL_BXL: begin
            bxl_d = spr_req_in.wdata & ccxr_pkg::BXL_WMASK;
            ack_d = 1'h1;
          end
        endcase
      end else begin
        ack_d = 1'h1;
        unique case (spr_req_in.sel)
          ccxr_pkg::CCXR_SEL_MSW:   rdata_d = msw_q;
          ccxr_pkg::CCXR_SEL_MODEL: rdata_d = MODEL_ID;
          ccxr_pkg::CCXR_SEL_BXU:   rdata_d = bxu_q;
          ccxr_pkg::CCXR_SEL_BXL:   rdata_d = bxl_q;
        endcase
      end
    end
    fpm_d = fp_decode(msw_d);
    fpp_d = fp_precise(msw_d);
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      msw_q   <= MSW_RESET;
      bxu_q   <= ccxr_pkg::BXU_RESET;
      bxl_q   <= ccxr_pkg::BXL_RESET;
      rdata_q <= 32'h0000_0000;
      ack_q   <= 1'h0;
      fault_q <= 1'h0;
      wide_q  <= IMPL_64;
      fpm_q   <= ccxr_pkg::CCXR_FP_OFF;
      fpp_q   <= 1'h0;
    end else if (ce_in) begin
      msw_q   <= msw_d;
      bxu_q   <= bxu_d;
      bxl_q   <= bxl_d;
      rdata_q <= rdata_d;
      ack_q   <= ack_d;
      fault_q <= fault_d;
      fpm_q   <= fpm_d;
      fpp_q   <= fpp_d;
    end
  end

  // ----------------------------------------------------------------------
  // block match
  // ----------------------------------------------------------------------
  ccxr_block_match u_match (
    .bxu_in        (bxu_q),
    .bxl_in        (bxl_q),
    .user_level_in (msw_q[ccxr_pkg::MSW_USER]),
    .ea_valid_in   (ea_valid_in),
    .ea_in         (ea_in),
    .match_out     (xl_d)
  );

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      xl_q <= '0;
    end else if (ce_in) begin
      xl_q <= xl_d;
    end
  end

  assign spr_ack_out      = ack_q;
  assign spr_fault_out    = fault_q;
  assign spr_rdata_out    = rdata_q;
  assign msw_out          = msw_q;
  assign wide_mode_64_out = wide_q;
  assign fp_mode_out      = fpm_q;
  assign fp_precise_out   = fpp_q;
  assign xlate_out        = xl_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence s_sup_req(logic wr, ccxr_pkg::ccxr_sel_t s);
    ce_in && spr_req_in.valid && !msw_q[ccxr_pkg::MSW_USER] &&
    spr_req_in.write == wr && spr_req_in.sel == s;
  endsequence

  property p_fp_decode;
    @(posedge sys_clk_in) disable iff (srst_in)
      fp_mode_out == fp_decode(msw_out) && fp_precise_out == fp_precise(msw_out);
  endproperty
  a_fp_decode: assert property (p_fp_decode) else $error("trap mode decode wrong");

  property p_fp_or;
    @(posedge sys_clk_in) disable iff (srst_in)
      FP_OR_MODE && (msw_out[ccxr_pkg::MSW_FPLO] || msw_out[ccxr_pkg::MSW_FPHI])
      |-> fp_precise_out;
  endproperty
  a_fp_or: assert property (p_fp_or) else $error("or-combined mode not precise");

  property p_reset_state;
    @(posedge sys_clk_in) srst_in |=> msw_out == MSW_RESET && wide_mode_64_out == IMPL_64;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad reset state");

  property p_vhb_reset;
    @(posedge sys_clk_in) srst_in |=> msw_out[ccxr_pkg::MSW_VHB] == VHB_RESET;
  endproperty
  a_vhb_reset: assert property (p_vhb_reset) else $error("vector base reset wrong");

  property p_model_read;
    @(posedge sys_clk_in) disable iff (srst_in)
      s_sup_req(1'h0, ccxr_pkg::CCXR_SEL_MODEL)
      |=> spr_ack_out && !spr_fault_out && spr_rdata_out == MODEL_ID;
  endproperty
  a_model_read: assert property (p_model_read) else $error("model id read wrong");

  property p_model_nowrite;
    @(posedge sys_clk_in) disable iff (srst_in)
      s_sup_req(1'h1, ccxr_pkg::CCXR_SEL_MODEL) |=> spr_fault_out && !spr_ack_out;
  endproperty
  a_model_nowrite: assert property (p_model_nowrite) else $error("model id written");

  property p_user_refused;
    @(posedge sys_clk_in) disable iff (srst_in)
      ce_in && spr_req_in.valid && msw_q[ccxr_pkg::MSW_USER]
      |=> spr_fault_out && !spr_ack_out && $stable(bxu_q) && $stable(bxl_q);
  endproperty
  a_user_refused: assert property (p_user_refused) else $error("user move accepted");

  property p_bxu_roundtrip;
    logic [31:0] v;
    @(posedge sys_clk_in) disable iff (srst_in)
      (s_sup_req(1'h1, ccxr_pkg::CCXR_SEL_BXU), v = spr_req_in.wdata)
      |=> bxu_q == (v & ccxr_pkg::BXU_WMASK) && spr_ack_out;
  endproperty
  a_bxu_roundtrip: assert property (p_bxu_roundtrip) else $error("upper readback wrong");

  property p_bxl_reserved;
    @(posedge sys_clk_in) disable iff (srst_in)
      (bxl_q & ~ccxr_pkg::BXL_WMASK) == 32'h0000_0000 &&
      (bxu_q & ~ccxr_pkg::BXU_WMASK) == 32'h0000_0000;
  endproperty
  a_bxl_reserved: assert property (p_bxl_reserved) else $error("reserved bit set");

  property p_no_valid_no_hit;
    @(posedge sys_clk_in) disable iff (srst_in)
      ce_in && (msw_q[ccxr_pkg::MSW_USER] ? !bxu_q[ccxr_pkg::BXU_USER_V]
                                          : !bxu_q[ccxr_pkg::BXU_PRIV_V])
      |=> !xlate_out.hit;
  endproperty
  a_no_valid_no_hit: assert property (p_no_valid_no_hit) else $error("hit without valid");

  property p_hit_fields;
    @(posedge sys_clk_in) disable iff (srst_in)
      ce_in && ea_valid_in ##1 xlate_out.hit
      |-> xlate_out.cache_attr == $past(bxl_q[ccxr_pkg::BXL_ATTR_LSB +: 4]) &&
          xlate_out.access_guard == $past(bxl_q[1:0]);
  endproperty
  a_hit_fields: assert property (p_hit_fields) else $error("hit attributes wrong");

  sequence s_bxl_write;
    s_sup_req(1'h1, ccxr_pkg::CCXR_SEL_BXL);
  endsequence

  property p_bxl_write;
    logic [31:0] v;
    @(posedge sys_clk_in) disable iff (srst_in)
      (s_bxl_write, v = spr_req_in.wdata)
      |=> bxl_q == (v & ccxr_pkg::BXL_WMASK) && spr_ack_out;
  endproperty
  a_bxl_write: assert property (p_bxl_write) else $error("lower write lost");

  property p_msw_write;
    logic [31:0] v;
    @(posedge sys_clk_in) disable iff (srst_in)
      (s_sup_req(1'h1, ccxr_pkg::CCXR_SEL_MSW), v = spr_req_in.wdata)
      |=> msw_out == v && spr_ack_out;
  endproperty
  a_msw_write: assert property (p_msw_write) else $error("state word write lost");

  property p_ack_xor_fault;
    @(posedge sys_clk_in) disable iff (srst_in)
      !(spr_ack_out && spr_fault_out);
  endproperty
  a_ack_xor_fault: assert property (p_ack_xor_fault) else $error("ack and fault together");

  // enable low must hold the state word, block, response and translation registers, outputs included
  property p_ce_freeze;
    @(posedge sys_clk_in) disable iff (srst_in)
      !ce_in |=> $stable(msw_out) && $stable(bxu_q) && $stable(bxl_q) &&
                 $stable(spr_ack_out) && $stable(spr_fault_out) &&
                 $stable(spr_rdata_out) && $stable(xlate_out);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with enable low");

  property p_no_ea_no_hit;
    @(posedge sys_clk_in) disable iff (srst_in)
      ce_in && !ea_valid_in |=> !xlate_out.hit;
  endproperty
  a_no_ea_no_hit: assert property (p_no_ea_no_hit) else $error("hit without address");

  property p_wide_mode;
    @(posedge sys_clk_in) disable iff (srst_in)
      wide_mode_64_out == IMPL_64;
  endproperty
  a_wide_mode: assert property (p_wide_mode) else $error("wide mode moved");

endmodule

// file: dv/test_ccxr_regs.sv
// self-checking bench for the cpu config, model id and block translation bank.
// assumes ccxr_pkg is compiled first; inputs change on the falling clock edge.

module test_ccxr_regs;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------------
  // stimulus constants
  // ----------------------------------------------------------------------
  localparam int          MAX_CYCLES = 2000;
  // state word bits that have a defined value after reset
  localparam logic [31:0] MSW_DEF    = 32'h0005_ff73;
  localparam logic        FP_OR      = 1'b1;
  // arbitrary identification values
  localparam logic [15:0] VER_ID     = 16'h0b17;
  localparam logic [15:0] REV_ID     = 16'h0003;
  localparam logic [14:0] IDX        = 15'h1234;
  localparam logic [14:0] PHYS       = 15'h2d2d;
  localparam logic [3:0]  ATTR       = 4'ha;
  localparam logic [1:0]  GUARD      = 2'h2;

  logic                    sys_clk_in;
  logic                    srst_in;
  logic                    ce_in;
  ccxr_pkg::ccxr_spr_req_t spr_req_in;
  logic                    ea_valid_in;
  logic [31:0]             ea_in;
  logic                    spr_ack_out;
  logic                    spr_fault_out;
  logic [31:0]             spr_rdata_out;
  logic [31:0]             msw_out;
  logic                    wide_mode_64_out;
  ccxr_pkg::ccxr_fp_mode_t fp_mode_out;
  logic                    fp_precise_out;
  ccxr_pkg::ccxr_xlate_t   xlate_out;
  int                      miscompares  = 0;
  int                      total_checks = 0;
  int                      cycles       = 0;
  logic [31:0]             w;

  ccxr_regs #(
    .FP_OR_MODE (FP_OR),
    .MODEL_VER (VER_ID),
    .MODEL_REV (REV_ID)
  ) i_ccxr_regs (
    .sys_clk_in       (sys_clk_in),
    .srst_in          (srst_in),
    .ce_in            (ce_in),
    .spr_req_in       (spr_req_in),
    .ea_valid_in      (ea_valid_in),
    .ea_in            (ea_in),
    .spr_ack_out      (spr_ack_out),
    .spr_fault_out    (spr_fault_out),
    .spr_rdata_out    (spr_rdata_out),
    .msw_out          (msw_out),
    .wide_mode_64_out (wide_mode_64_out),
    .fp_mode_out      (fp_mode_out),
    .fp_precise_out   (fp_precise_out),
    .xlate_out        (xlate_out)
  );

  // ----------------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------------
  initial begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end

  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == MAX_CYCLES) begin
      miscompares++;
      final_report();
    end
  end

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one move request; resp is the expected {ack, fault}
  task automatic spr(input logic wr, input ccxr_pkg::ccxr_sel_t sel, input logic [31:0] wd,
                     input logic [1:0] resp);
    @(negedge sys_clk_in);
    spr_req_in = '{valid: 1'b1, write: wr, sel: sel, wdata: wd};
    @(negedge sys_clk_in);
    check({30'h0, spr_ack_out, spr_fault_out}, {30'h0, resp});
    spr_req_in.valid = 1'b0;
  endtask

  task automatic rd(input ccxr_pkg::ccxr_sel_t sel, input logic [31:0] exp);
    spr(1'b0, sel, 32'h0000_0000, 2'h2);
    check(spr_rdata_out, exp);
  endtask

  // present an address; on an expected miss only the hit flag is compared
  task automatic xl(input logic vld, input logic [31:0] ea, input ccxr_pkg::ccxr_xlate_t exp);
    @(negedge sys_clk_in);
    ea_valid_in = vld;
    ea_in = ea;
    @(negedge sys_clk_in);
    if (exp.hit) check({10'h0, xlate_out}, {10'h0, exp});
    else check({31'h0, xlate_out.hit}, 32'h0000_0000);
  endtask

  function automatic logic [14:0] phys_of(input logic [14:0] ea_idx, input logic [10:0] m);
    return (PHYS & ~{4'h0, m}) | (ea_idx & {4'h0, m});
  endfunction

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    srst_in = 1'b1;
    ce_in = 1'b1;
    spr_req_in = '0;
    ea_valid_in = 1'b0;
    ea_in = 32'h0000_0000;
    repeat (5) @(negedge sys_clk_in);
    srst_in = 1'b0;
    check(msw_out & MSW_DEF, 32'h0000_0040);
    check({31'h0, wide_mode_64_out}, 32'h0000_0000);
    check({30'h0, fp_mode_out}, 32'h0000_0000);
    check({31'h0, fp_precise_out}, 32'h0000_0000);
    spr(1'b0, ccxr_pkg::CCXR_SEL_MSW, 32'h0000_0000, 2'h2);
    check(spr_rdata_out & MSW_DEF, 32'h0000_0040);
    $display("test reset_state done");

    rd(ccxr_pkg::CCXR_SEL_MODEL, {VER_ID, REV_ID});
    spr(1'b1, ccxr_pkg::CCXR_SEL_MODEL, 32'hffff_ffff, 2'h1);
    rd(ccxr_pkg::CCXR_SEL_MODEL, {VER_ID, REV_ID});
    $display("test model_id done");

    for (int i = 0; i < 4; i++) begin
      w = (32'(i / 2) << ccxr_pkg::MSW_FPLO) | (32'(i % 2) << ccxr_pkg::MSW_FPHI);
      spr(1'b1, ccxr_pkg::CCXR_SEL_MSW, w, 2'h2);
      check({30'h0, fp_mode_out}, 32'(i));
      check({31'h0, fp_precise_out}, 32'(FP_OR ? i != 0 : i == 3));
    end
    $display("test fp_modes done");

    spr(1'b1, ccxr_pkg::CCXR_SEL_BXU, 32'hffff_ffff, 2'h2);
    rd(ccxr_pkg::CCXR_SEL_BXU, 32'hfffe_1fff);
    spr(1'b1, ccxr_pkg::CCXR_SEL_BXL, 32'hffff_ffff, 2'h2);
    rd(ccxr_pkg::CCXR_SEL_BXL, 32'hfffe_007b);
    w = {IDX, 4'h0, 11'h00f, 1'b1, 1'b0};
    spr(1'b1, ccxr_pkg::CCXR_SEL_BXU, w, 2'h2);
    rd(ccxr_pkg::CCXR_SEL_BXU, w);
    w = {PHYS, 10'h0, ATTR, 1'b0, GUARD};
    spr(1'b1, ccxr_pkg::CCXR_SEL_BXL, w, 2'h2);
    rd(ccxr_pkg::CCXR_SEL_BXL, w);
    $display("test block_regs done");

    xl(1'b1, {IDX ^ 15'h0005, 17'h1abc},
       '{1'b1, phys_of(IDX ^ 15'h0005, 11'h00f), ATTR, GUARD});
    xl(1'b1, {IDX ^ 15'h0010, 17'h0000}, '0);
    xl(1'b0, {IDX, 17'h0000}, '0);
    spr(1'b1, ccxr_pkg::CCXR_SEL_BXU, {IDX, 4'h0, 11'h7ff, 1'b1, 1'b0}, 2'h2);
    xl(1'b1, {IDX ^ 15'h07ff, 17'h0000},
       '{1'b1, phys_of(IDX ^ 15'h07ff, 11'h7ff), ATTR, GUARD});
    xl(1'b1, {IDX ^ 15'h0800, 17'h0000}, '0);
    spr(1'b1, ccxr_pkg::CCXR_SEL_BXU, {IDX, 4'h0, 11'h000, 1'b0, 1'b1}, 2'h2);
    xl(1'b1, {IDX, 17'h0000}, '0);
    $display("test block_match done");

    spr(1'b1, ccxr_pkg::CCXR_SEL_MSW, 32'h1 << ccxr_pkg::MSW_USER, 2'h2);
    xl(1'b1, {IDX, 17'h0000}, '{1'b1, PHYS, ATTR, GUARD});
    spr(1'b0, ccxr_pkg::CCXR_SEL_MODEL, 32'h0000_0000, 2'h1);
    spr(1'b1, ccxr_pkg::CCXR_SEL_BXU, 32'h0000_0000, 2'h1);
    xl(1'b1, {IDX, 17'h0000}, '{1'b1, PHYS, ATTR, GUARD});
    $display("test user_level done");

    @(negedge sys_clk_in);
    srst_in = 1'b1;
    ea_valid_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    srst_in = 1'b0;
    check(msw_out & MSW_DEF, 32'h0000_0040);
    check({10'h0, xlate_out}, 32'h0000_0000);
    rd(ccxr_pkg::CCXR_SEL_BXU, 32'h0000_0000);
    $display("test second_reset done");

    // a request while the enable is low is neither answered nor applied
    @(negedge sys_clk_in);
    ce_in = 1'b0;
    spr(1'b1, ccxr_pkg::CCXR_SEL_BXU, 32'hffff_ffff, 2'h0);
    @(negedge sys_clk_in);
    ce_in = 1'b1;
    rd(ccxr_pkg::CCXR_SEL_BXU, 32'h0000_0000);
    $display("test clock_enable done");
    final_report();
  end
endmodule
